// [logic/adc_cmd_defs.vh]
`ifndef ADC_CMD_DEFS_VH
`define ADC_CMD_DEFS_VH

// Command byte selector bits
`define CMD_CONV_BIT 7
`define CMD_SETUP_BIT 6
`define CMD_AVG_BIT 5
`define CMD_RESET_BIT 4

// Conversion byte fields
`define CONV_CH_HI 6
`define CONV_CH_LO 3
`define CONV_SCAN_HI 2
`define CONV_SCAN_LO 1
`define CONV_TEMP_BIT 0

// Setup byte fields
`define SETUP_CLK_HI 5
`define SETUP_CLK_LO 4
`define SETUP_REF_HI 3
`define SETUP_REF_LO 2
`define SETUP_PAIR_HI 1
`define SETUP_PAIR_LO 0

// Averaging byte fields
`define AVG_EN_BIT 4
`define AVG_CNT_HI 3
`define AVG_CNT_LO 2
`define AVG_REP_HI 1
`define AVG_REP_LO 0

// Reset byte field
`define RESET_KIND_BIT 3

// Encodings
`define SCAN_LOW_RANGE 2'h0
`define SCAN_HIGH_RANGE 2'h1
`define SCAN_REPEAT 2'h2
`define SCAN_SINGLE 2'h3
`define CLK_EXTERNAL 2'h3
`define REF_EXT_DIFF 2'h3
`define PAIR_SEL_UNIPOLAR 2'h2
`define PAIR_SEL_BIPOLAR 2'h3

// Power-up values
`define CONV_RESET 8'h00
`define SETUP_RESET 6'h20
`define AVG_RESET 5'h00
`define PAIR_RESET 8'h00

`endif

// [logic/adc_command_byte_decoder.v]
`timescale 1ns/10ps
`include "adc_cmd_defs.vh"

// Summary of operation
// R1: Byte with bit 7 set is a conversion request: channel, scan mode, temperature.
// R2: Four-bit channel field is an unsigned index, inputs 0 to 15.
// R3: Scan mode 00 converts channels 0 through N.
// R4: Scan mode 01 converts channels N through the top channel.
// R5: Scan mode 10 converts N repeatedly, count from averaging register field.
// R6: Scan mode 11 converts channel N exactly once.
// R7: Range scans give one result per single channel or pair, plus temperature.
// R8: Temperature flag adds one temperature result, placed first in the scan.
// R9: Clock modes 1x start on conversion write, 0x on start pin low pulse.
// R10: Channels used as start pin or negative reference are skipped.
// R11: Host selects a pair by its lower-numbered channel.
// R12: Top pair with a member reassigned as start or reference is ignored.
// R13: Host never requests channels the part does not have.
// R14: Setup bits 5 and 4 select the clock mode.
// R15: Setup bits 3 and 2 select and keep the reference mode.
// R16: Setup pair bits 10 or 11 route the next byte to a pair register.
// R17: Host holds chip select for 16 clocks for setup plus pair byte.
// R18: Setup pair bits 00 or 01 leave pair registers, next byte is a command.
// R19: A pair flagged unipolar and bipolar is treated as unipolar.
// R20: Unipolar pairs are straight binary, bipolar pairs two's complement.
// R21: Averaging of up to 32 samples only while averaging enable is set.
// R22: Clock mode 11 disables averaging regardless of the enable.
// R23: Bit 7 low and bit 6 high is a setup write.
// R24: Bits 7 and 6 low, bit 5 high is an averaging write.
// R25: Reset byte: bit 1 clears the result store, 0 restores all defaults.
// R26: Power-up: registers zero, setup in clock mode 10.
// R27: Target register is the highest set bit of 7..4, except pair data.
module adc_command_byte_decoder #(
  parameter NUM_CHANNELS = 16
) (
  input wire clk_sys_in,
  input wire reset_in,
  input wire sclk_in,
  input wire cs_n_in,
  input wire din_in,
  input wire conversion_start_pin_n_in,
  input wire conv_ready_in,
  output reg conv_valid_out,
  output reg [3:0] conv_channel_out,
  output reg conv_temp_out,
  output reg conv_diff_out,
  output reg conv_bipolar_out,
  output wire scan_busy_out,
  output wire [1:0] clock_mode_out,
  output wire [1:0] reference_sel_out,
  output wire [7:0] unipolar_pair_out,
  output wire [7:0] bipolar_pair_out,
  output wire averaging_active_out,
  output wire [1:0] average_count_out,
  output wire [1:0] repeat_count_out,
  output reg fifo_clear_out
);

  localparam [3:0] TOP_CH = NUM_CHANNELS[3:0] - 4'h1;
  localparam [3:0] REFM_CH = NUM_CHANNELS[3:0] - 4'h2;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RUN = 2'h1;

  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  reg [3:0] prev_reg;
  reg [6:0] shift_reg;
  reg [2:0] bit_cnt_reg;
  reg pair_pend_reg;
  reg pair_bip_reg;
  reg [7:0] conv_request_reg;
  reg [5:0] setup_config_reg;
  reg [4:0] averaging_config_reg;
  reg [7:0] unipolar_pair_select_reg;
  reg [7:0] bipolar_pair_select_reg;
  reg [1:0] state_reg;
  reg [3:0] cur_ch_reg;
  reg [3:0] last_ch_reg;
  reg [3:0] rep_left_reg;
  reg single_reg;
  reg temp_pend_reg;

  wire sclk_s = sync2_reg[0];
  wire cs_n_s = sync2_reg[1];
  wire din_s = sync2_reg[2];
  wire conversion_start_pin_n_s = sync2_reg[3];
  wire sclk_rise = sclk_s & ~prev_reg[0];
  wire cs_rise = cs_n_s & ~prev_reg[1];
  wire conversion_start_pin_fall = ~conversion_start_pin_n_s & prev_reg[3];
  wire bit_take = sclk_rise & ~cs_n_s;
  wire byte_done = bit_take & (bit_cnt_reg == 3'h7);
  wire [7:0] rx_byte = {shift_reg, din_s};

  // Pin modes derived from the stored setup
  wire [1:0] clk_mode = setup_config_reg[`SETUP_CLK_HI:`SETUP_CLK_LO];
  wire conversion_start_pin_pin_mode = ~clk_mode[1];
  wire refm_pin_mode = setup_config_reg[`SETUP_REF_HI:`SETUP_REF_LO] == `REF_EXT_DIFF;

  // Byte class by highest set bit
  // R27: priority decode
  wire is_pair_data = byte_done & pair_pend_reg;
  // R1: conversion class
  wire is_conv = byte_done & ~pair_pend_reg & rx_byte[`CMD_CONV_BIT];
  // R23: setup class
  wire is_setup = byte_done & ~pair_pend_reg & ~rx_byte[`CMD_CONV_BIT] &
    rx_byte[`CMD_SETUP_BIT];
  // R24: averaging class
  wire is_avg = byte_done & ~pair_pend_reg & (rx_byte[7:6] == 2'h0) &
    rx_byte[`CMD_AVG_BIT];
  wire is_reset = byte_done & ~pair_pend_reg & (rx_byte[7:5] == 3'h0) &
    rx_byte[`CMD_RESET_BIT];
  wire full_reset = is_reset & ~rx_byte[`RESET_KIND_BIT];

  assign clock_mode_out = clk_mode;
  assign reference_sel_out = setup_config_reg[`SETUP_REF_HI:`SETUP_REF_LO];
  assign unipolar_pair_out = unipolar_pair_select_reg;
  assign bipolar_pair_out = bipolar_pair_select_reg;
  // R21: averaging only when enabled
  // R22: external clock mode overrides the enable
  assign averaging_active_out = averaging_config_reg[`AVG_EN_BIT] & (clk_mode != `CLK_EXTERNAL);
  assign average_count_out = averaging_config_reg[`AVG_CNT_HI:`AVG_CNT_LO];
  assign repeat_count_out = averaging_config_reg[`AVG_REP_HI:`AVG_REP_LO];
  assign scan_busy_out = (state_reg != ST_IDLE) | conv_valid_out;

  // Two-stage synchronisers, then one stage for edge detection
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      sync1_reg <= 4'hb;
      sync2_reg <= 4'hb;
      prev_reg <= 4'hb;
    end else begin
      sync1_reg <= {conversion_start_pin_n_in, din_in, cs_n_in, sclk_in};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Serial shifter, MSB first on rising serial clock; framing restarts at chip select high
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      shift_reg <= 7'h00;
      bit_cnt_reg <= 3'h0;
    end else if (cs_n_s) begin
      bit_cnt_reg <= 3'h0;
    end else if (bit_take) begin
      shift_reg <= rx_byte[6:0];
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // Register writes; a full reset byte restores the power-up image
  always @(posedge clk_sys_in) begin
    if (reset_in || full_reset) begin
      // R25: full restore
      // R26: power-up image
      conv_request_reg <= `CONV_RESET;
      setup_config_reg <= `SETUP_RESET;
      averaging_config_reg <= `AVG_RESET;
      unipolar_pair_select_reg <= `PAIR_RESET;
      bipolar_pair_select_reg <= `PAIR_RESET;
      pair_pend_reg <= 1'b0;
      pair_bip_reg <= 1'b0;
    end else begin
      if (is_conv) begin
        conv_request_reg <= rx_byte;
      end
      // R14: clock mode field
      // R15: reference field kept
      if (is_setup) begin
        setup_config_reg <= rx_byte[5:0];
      end
      if (is_avg) begin
        averaging_config_reg <= rx_byte[4:0];
      end
      // R16: arm pair data byte
      // R18: 00 and 01 arm nothing
      if (is_setup) begin
        pair_pend_reg <= rx_byte[`SETUP_PAIR_HI];
        pair_bip_reg <= rx_byte[`SETUP_PAIR_LO];
      end else if (is_pair_data || cs_rise) begin
        pair_pend_reg <= 1'b0;
      end
      // R16: pair data write
      if (is_pair_data && !pair_bip_reg) begin
        unipolar_pair_select_reg <= rx_byte;
      end
      if (is_pair_data && pair_bip_reg) begin
        bipolar_pair_select_reg <= rx_byte;
      end
    end
  end

  // Result store clear is a one-cycle pulse
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      fifo_clear_out <= 1'b0;
    end else begin
      // R25: clear store only
      fifo_clear_out <= is_reset & rx_byte[`RESET_KIND_BIT];
    end
  end

  // Start source depends on clock mode; requests during a scan are dropped
  wire [7:0] req = is_conv ? rx_byte : conv_request_reg;
  // R9: start source select
  wire start = (state_reg == ST_IDLE) && !conv_valid_out &&
    (clk_mode[1] ? is_conv : conversion_start_pin_fall);
  // R2: unsigned channel index
  wire [3:0] req_ch = req[`CONV_CH_HI:`CONV_CH_LO];
  wire [1:0] req_scan = req[`CONV_SCAN_HI:`CONV_SCAN_LO];
  wire [2:0] req_pidx = 3'h7 - req_ch[3:1];
  wire req_paired = unipolar_pair_select_reg[req_pidx] | bipolar_pair_select_reg[req_pidx];

  // Candidate evaluation for the channel under the scan pointer
  wire [2:0] pidx = 3'h7 - cur_ch_reg[3:1];
  wire uni_flag = unipolar_pair_select_reg[pidx];
  wire bip_flag = bipolar_pair_select_reg[pidx];
  wire paired = uni_flag | bip_flag;
  wire [3:0] lower_ch = {cur_ch_reg[3:1], 1'b0};
  wire [3:0] upper_ch = {cur_ch_reg[3:1], 1'b1};
  // R10: reassigned pins excluded
  wire excl_cur = (conversion_start_pin_pin_mode && cur_ch_reg == TOP_CH) ||
    (refm_pin_mode && cur_ch_reg == REFM_CH);
  wire excl_lo = (conversion_start_pin_pin_mode && lower_ch == TOP_CH) ||
    (refm_pin_mode && lower_ch == REFM_CH);
  wire excl_hi = (conversion_start_pin_pin_mode && upper_ch == TOP_CH) ||
    (refm_pin_mode && upper_ch == REFM_CH);
  // R7: one result per pair, odd member folded in
  // R12: pair dropped if a member is reassigned
  wire emit = paired ? (~cur_ch_reg[0] & ~excl_lo & ~excl_hi) : ~excl_cur;
  wire out_free = !conv_valid_out || conv_ready_in;

  // Scan sequencer
  always @(posedge clk_sys_in) begin
    if (reset_in || full_reset) begin
      state_reg <= ST_IDLE;
      cur_ch_reg <= 4'h0;
      last_ch_reg <= 4'h0;
      rep_left_reg <= 4'h0;
      single_reg <= 1'b0;
      temp_pend_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_RUN;
            // R8: temperature result first
            temp_pend_reg <= req[`CONV_TEMP_BIT];
            single_reg <= req_scan[1];
            case (req_scan)
              // R3: zero up to N
              `SCAN_LOW_RANGE: begin
                cur_ch_reg <= 4'h0;
                last_ch_reg <= req_ch;
              end
              // R4: N up to the top
              `SCAN_HIGH_RANGE: begin
                cur_ch_reg <= req_ch;
                last_ch_reg <= TOP_CH;
              end
              default: begin
                cur_ch_reg <= req_paired ? {req_ch[3:1], 1'b0} : req_ch;
                last_ch_reg <= req_ch;
              end
            endcase
            // R5: repeat count, four results per step
            // R6: single result
            rep_left_reg <= (req_scan == `SCAN_REPEAT) ?
              {averaging_config_reg[`AVG_REP_HI:`AVG_REP_LO], 2'h3} :
              4'h0;
          end
        end
        ST_RUN: begin
          if (out_free && !temp_pend_reg) begin
            if (single_reg) begin
              if (rep_left_reg == 4'h0 || !emit) begin
                state_reg <= ST_IDLE;
              end else begin
                rep_left_reg <= rep_left_reg - 4'h1;
              end
            end else if (cur_ch_reg == last_ch_reg) begin
              state_reg <= ST_IDLE;
            end else begin
              cur_ch_reg <= cur_ch_reg + 4'h1;
            end
          end else if (out_free) begin
            temp_pend_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Result request register toward the converter
  always @(posedge clk_sys_in) begin
    if (reset_in || full_reset) begin
      conv_valid_out <= 1'b0;
      conv_channel_out <= 4'h0;
      conv_temp_out <= 1'b0;
      conv_diff_out <= 1'b0;
      conv_bipolar_out <= 1'b0;
    end else if (out_free) begin
      if (state_reg == ST_RUN && temp_pend_reg) begin
        conv_valid_out <= 1'b1;
        conv_channel_out <= 4'h0;
        conv_temp_out <= 1'b1;
        conv_diff_out <= 1'b0;
        conv_bipolar_out <= 1'b0;
      end else if (state_reg == ST_RUN && emit) begin
        conv_valid_out <= 1'b1;
        conv_channel_out <= cur_ch_reg;
        conv_temp_out <= 1'b0;
        conv_diff_out <= paired;
        // R19: unipolar wins
        // R20: coding flag
        conv_bipolar_out <= bip_flag & ~uni_flag;
      end else begin
        conv_valid_out <= 1'b0;
      end
    end
  end

endmodule

// [tb/adc_cmd_chk.sv]
`timescale 1ns/10ps
// Port checks of the command decoder, bound to its top
module adc_cmd_chk #(
  parameter NUM_CHANNELS = 16
) (
  input wire clk_sys_in,
  input wire reset_in,
  input wire conv_ready_in,
  input wire conv_valid_out,
  input wire [3:0] conv_channel_out,
  input wire conv_temp_out,
  input wire conv_diff_out,
  input wire conv_bipolar_out,
  input wire scan_busy_out,
  input wire [1:0] clock_mode_out,
  input wire [1:0] reference_sel_out,
  input wire [7:0] unipolar_pair_out,
  input wire [7:0] bipolar_pair_out,
  input wire averaging_active_out,
  input wire fifo_clear_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // Pair flag index: bit 7 holds pair 0/1
  wire [2:0] pidx = 3'h7 - conv_channel_out[3:1];
  sequence s_stall;
    conv_valid_out && !conv_ready_in;
  endsequence
  sequence s_start;
    $rose(scan_busy_out);
  endsequence
  reset_dflt_a:
    assert property ($fell(reset_in) |-> clock_mode_out == 2'h2 && reference_sel_out == 2'h0
      && unipolar_pair_out == 8'h00 && bipolar_pair_out == 8'h00 && !conv_valid_out)
    else $error("registers not at defaults after reset");
  req_hold_a:
    assert property (s_stall |=> conv_valid_out && $stable(conv_channel_out)
      && $stable(conv_temp_out) && $stable(conv_diff_out))
    else $error("request changed before acceptance");
  start_req_a:
    assert property (s_start |-> ##[1:40] (conv_valid_out || !scan_busy_out))
    else $error("scan started but gave no request");
  temp_chan_a:
    assert property (conv_valid_out && conv_temp_out |-> conv_channel_out == 4'h0 && !conv_diff_out)
    else $error("temperature request malformed");
  pair_even_a:
    assert property (conv_valid_out && conv_diff_out |-> !conv_channel_out[0])
    else $error("pair request on odd channel");
  pair_code_a:
    assert property (conv_valid_out && conv_diff_out |->
      conv_bipolar_out == (bipolar_pair_out[pidx] && !unipolar_pair_out[pidx]))
    else $error("pair coding wrong");
  skip_pin_a:
    assert property (conv_valid_out && !conv_temp_out |->
      !(!clock_mode_out[1] && conv_channel_out == NUM_CHANNELS - 1)
      && !(reference_sel_out == 2'h3 && conv_channel_out == NUM_CHANNELS - 2))
    else $error("reassigned input was converted");
  avg_off_a:
    assert property (clock_mode_out == 2'h3 |-> !averaging_active_out)
    else $error("averaging active in external clock mode");
  clr_pulse_a:
    assert property (fifo_clear_out |=> !fifo_clear_out)
    else $error("fifo clear longer than one cycle");
endmodule

// [tb/serial_host.sv]
`timescale 1ns/10ps
// Host side of the serial link; sclk stands high between frames
module serial_host (
  input wire clk_sys_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic din_out,
  output logic start_n_out
);
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    din_out = 1'b0;
    start_n_out = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // Data changes while sclk is low, taken on its rise, MSB first
  task automatic shift_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sclk_out = 1'b0;
      din_out = b[i];
      wait_clk(4);
      sclk_out = 1'b1;
      wait_clk(4);
    end
  endtask
  task automatic open_frame;
    wait_clk(1);
    cs_n_out = 1'b0;
    wait_clk(4);
  endtask
  // Released data line flips so no stale bit can be mistaken for data
  task automatic close_frame;
    wait_clk(4);
    cs_n_out = 1'b1;
    din_out = ~din_out;
    wait_clk(12);
  endtask
  task automatic send1(input logic [7:0] b);
    open_frame();
    shift_byte(b);
    close_frame();
  endtask
  // pair byte rides in the same 16-clock frame
  task automatic send2(input logic [15:0] w);
    open_frame();
    shift_byte(w[15:8]);
    shift_byte(w[7:0]);
    close_frame();
  endtask
  // start pin low pulse from the host
  task automatic start_pulse;
    wait_clk(1);
    start_n_out = 1'b0;
    wait_clk(4);
    start_n_out = 1'b1;
    wait_clk(4);
  endtask
endmodule

// [tb/tb_adc_command_byte_decoder.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_adc_command_byte_decoder;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic conv_ready_in = 1'b0;
  wire sclk_in, cs_n_in, din_in, conversion_start_pin_n_in;
  wire conv_valid_out, conv_temp_out, conv_diff_out, conv_bipolar_out, scan_busy_out;
  wire averaging_active_out, fifo_clear_out;
  wire [3:0] conv_channel_out;
  wire [1:0] clock_mode_out, reference_sel_out, average_count_out, repeat_count_out;
  wire [7:0] unipolar_pair_out, bipolar_pair_out;
  logic [6:0] got[$];
  int bad_count = 0;
  int n_compared = 0;
  int clr_seen = 0;
  // All configuration outputs in one word for compact compares
  wire [24:0] cfg = {clock_mode_out, reference_sel_out, unipolar_pair_out, bipolar_pair_out,
    averaging_active_out, average_count_out, repeat_count_out};
  initial forever #20 clk_sys_in = ~clk_sys_in;
  // bench requests only channels of the 16-input part
  adc_command_byte_decoder #(.NUM_CHANNELS(16)) dut (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .din_in(din_in),
    .conversion_start_pin_n_in(conversion_start_pin_n_in),
    .conv_ready_in(conv_ready_in),
    .conv_valid_out(conv_valid_out),
    .conv_channel_out(conv_channel_out),
    .conv_temp_out(conv_temp_out),
    .conv_diff_out(conv_diff_out),
    .conv_bipolar_out(conv_bipolar_out),
    .scan_busy_out(scan_busy_out),
    .clock_mode_out(clock_mode_out),
    .reference_sel_out(reference_sel_out),
    .unipolar_pair_out(unipolar_pair_out),
    .bipolar_pair_out(bipolar_pair_out),
    .averaging_active_out(averaging_active_out),
    .average_count_out(average_count_out),
    .repeat_count_out(repeat_count_out),
    .fifo_clear_out(fifo_clear_out)
  );
  serial_host host (
    .clk_sys_in(clk_sys_in),
    .sclk_out(sclk_in),
    .cs_n_out(cs_n_in),
    .din_out(din_in),
    .start_n_out(conversion_start_pin_n_in)
  );
  // Log accepted requests as {temp, diff, bipolar, channel}
  always @(posedge clk_sys_in) begin
    if (conv_valid_out === 1'b1 && conv_ready_in)
      got.push_back({conv_temp_out, conv_diff_out, conv_bipolar_out, conv_channel_out});
    if (fifo_clear_out === 1'b1)
      clr_seen++;
  end
  // Converter stalls every other cycle so requests must hold
  always @(negedge clk_sys_in) conv_ready_in <= ~conv_ready_in;
  task automatic check_scan(input logic [6:0] exp[$]);
    int n;
    n = 0;
    while (scan_busy_out !== 1'b0 && n < 300) begin
      @(negedge clk_sys_in);
      n++;
    end
    // A scan that never ends is a failure in its own right
    if (n == 300) bad_count++;
    `CHK(got.size(), exp.size())
    foreach (exp[i]) if (i < got.size()) `CHK(got[i], exp[i])
    got.delete();
  endtask
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // The run needs under two thousand cycles; a hang is cut well beyond that
  initial begin
    repeat (30000) @(posedge clk_sys_in);
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(negedge clk_sys_in);
    reset_in = 1'b0;
    repeat (6) @(negedge clk_sys_in);
    `CHK(cfg, 25'h1000000)
    host.send1(8'haf);
    check_scan('{7'h40, 7'h05});
    host.send1(8'h98);
    check_scan('{7'h00, 7'h01, 7'h02, 7'h03});
    host.send1(8'hea);
    check_scan('{7'h0d, 7'h0e, 7'h0f});
    host.send1(8'h31);
    `CHK(cfg, 25'h1000011)
    host.send1(8'hcc);
    check_scan('{7'h09, 7'h09, 7'h09, 7'h09, 7'h09, 7'h09, 7'h09, 7'h09});
    host.send2(16'h6280);
    host.send2(16'h63a0);
    `CHK(cfg, 25'h1101411)
    host.send1(8'ha8);
    check_scan('{7'h20, 7'h02, 7'h03, 7'h34});
    // pair asked by its lower channel
    host.send1(8'h86);
    check_scan('{7'h20});
    host.send2(16'h6030);
    `CHK(cfg, 25'h1101410)
    host.send1(8'h70);
    `CHK(cfg, 25'h1901400)
    host.send1(8'h96);
    check_scan('{7'h02});
    host.send1(8'h4c);
    host.send1(8'he2);
    `CHK(got.size(), 0)
    host.start_pulse();
    check_scan('{7'h0c, 7'h0d});
    host.send1(8'h05);
    `CHK(cfg, 25'h0701410)
    host.send1(8'h18);
    `CHK(clr_seen, 1)
    host.send1(8'h10);
    `CHK(cfg, 25'h1000000)
    report_and_stop();
  end
endmodule
bind adc_command_byte_decoder adc_cmd_chk #(.NUM_CHANNELS(NUM_CHANNELS)) chk (
  .clk_sys_in(clk_sys_in), .reset_in(reset_in), .conv_ready_in(conv_ready_in),
  .conv_valid_out(conv_valid_out), .conv_channel_out(conv_channel_out),
  .conv_temp_out(conv_temp_out), .conv_diff_out(conv_diff_out),
  .conv_bipolar_out(conv_bipolar_out), .scan_busy_out(scan_busy_out),
  .clock_mode_out(clock_mode_out), .reference_sel_out(reference_sel_out),
  .unipolar_pair_out(unipolar_pair_out), .bipolar_pair_out(bipolar_pair_out),
  .averaging_active_out(averaging_active_out), .fifo_clear_out(fifo_clear_out));
